// [hdl/mid_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mid_params.svh"
module mid_core
  import mid_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Program memory
  output logic [12:0]      pm_addr_o,
  input  wire logic [13:0] pm_data_i,
  // File register space
  output logic [6:0]       file_raddr_o,
  input  wire logic [7:0]  file_rdata_i,
  output logic             file_we_o,
  output logic [6:0]       file_waddr_o,
  output logic [7:0]       file_wdata_o,
  // Port pins, asynchronous
  input  wire logic [7:0]  port_b_pins_i,
  // Hardware stack
  output logic             stack_push_o,
  output logic [12:0]      stack_push_addr_o,
  output logic             stack_pop_o,
  input  wire logic [12:0] stack_tos_i,
  // Page bits and neighbours
  input  wire logic [1:0]  pclath_page_i,
  input  wire logic        presc_on_timer_i,
  input  wire logic        wake_i,
  output logic             presc_clear_o,
  output logic             wdt_clear_o,
  output logic             int_enable_set_o,
  // Core state
  output logic [7:0]       acc_o,
  output logic             carry_o,
  output logic             digit_carry_flag_o,
  output logic             zero_o,
  output logic             timeout_status_bit_o,
  output logic             powerdown_status_bit_o,
  output logic             standby_o,
  output mid_quarter_t     quarter_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Fixed words first: casez takes the first match
  function automatic mid_dec_t decode(input logic [13:0] w);
    mid_dec_t d;
    d = '{no_operation, 1'b0, 1'b0};
    casez (w)
      `MID_STANDBY_WORD:      d.op = enter_standby;
      `MID_WDT_CLR_WORD:      d.op = clear_watchdog_count;
      `MID_RET_INT_WORD:      d.op = return_from_interrupt;
      `MID_RET_WORD:          d.op = return_from_call;
      14'b00_0000_1???_????: d.op = store_acc_to_file;
      14'b00_0001_1???_????: d.op = clear_file;
      14'b00_0001_0???_????: d.op = clear_accumulator;
      14'b00_0010_????_????: d.op = subtract_acc_from_file;
      14'b00_0011_????_????: d.op = decrement_file;
      14'b00_0100_????_????: d.op = or_acc_with_file;
      14'b00_0101_????_????: d.op = and_acc_with_file;
      14'b00_0110_????_????: d.op = xor_acc_with_file;
      14'b00_0111_????_????: d.op = add_acc_to_file;
      14'b00_1000_????_????: d.op = move_file;
      14'b00_1001_????_????: d.op = complement_file;
      14'b00_1010_????_????: d.op = increment_file;
      14'b00_1011_????_????: d.op = decrement_skip_zero;
      14'b00_1100_????_????: d.op = rotate_right_carry;
      14'b00_1101_????_????: d.op = rotate_left_carry;
      14'b00_1110_????_????: d.op = swap_file_nibbles;
      14'b00_1111_????_????: d.op = increment_skip_zero;
      14'b01_00??_????_????: d.op = bit_clear_file;
      14'b01_01??_????_????: d.op = bit_set_file;
      14'b01_10??_????_????: d.op = bit_test_skip_clear;
      14'b01_11??_????_????: d.op = bit_test_skip_set;
      14'b10_0???_????_????: d.op = call_subroutine;
      14'b10_1???_????_????: d.op = jump_absolute;
      14'b11_00??_????_????: d.op = load_literal_acc;
      14'b11_01??_????_????: d.op = return_with_literal;
      14'b11_1000_????_????: d.op = or_literal_acc;
      14'b11_1001_????_????: d.op = and_literal_acc;
      14'b11_1010_????_????: d.op = xor_literal_acc;
      14'b11_110?_????_????: d.op = subtract_acc_from_literal;
      14'b11_111?_????_????: d.op = add_literal_acc;
      default:               d.op = no_operation;
    endcase
    // Byte results follow the destination bit
    if ((w[13:12] == 2'b00) && (w[11:8] != 4'h0 || w[7]))
    begin
      d.wr_file = w[`MID_DEST_BIT];
      d.wr_acc  = !w[`MID_DEST_BIT];
    end
    if (d.op inside {bit_clear_file, bit_set_file})
      d.wr_file = 1'b1;
    // Every literal form, the returning one too, lands in the accumulator
    if (w[13:12] == 2'b11)
      d.wr_acc = 1'b1;
    return d;
  endfunction : decode

  // ****************************************************************
  // State and datapath
  // ****************************************************************
  mid_core_state_t s_q;
  mid_core_state_t s_d;
  mid_dec_t        dec;
  mid_alu_res_t    alu;
  logic [7:0]      alu_opnd;
  logic [6:0]      faddr;
  logic            exec;

  assign dec      = decode(s_q.instr);
  assign faddr    = s_q.instr[`MID_FILE_MSB:0];
  assign exec     = (s_q.quarter == Q4) && !s_q.asleep;
  // Literal forms take the operand from the word itself
  assign alu_opnd = (s_q.instr[13:12] == 2'b11) ? s_q.instr[`MID_LIT_MSB:0] : s_q.operand;

  mid_alu u_alu (
    .op_i      (dec.op),
    .acc_i     (s_q.acc),
    .opnd_i    (alu_opnd),
    .bit_sel_i (s_q.instr[`MID_BIT_MSB:`MID_BIT_LSB]),
    .carry_i   (s_q.carry),
    .res_o     (alu)
  );

  // Next state: quarter sequencing, operand read, execute at Q4
  always_comb
  begin
    s_d                = s_q;
    s_d.pins_meta      = port_b_pins_i;
    s_d.pins_sync      = s_q.pins_meta;
    s_d.file_we        = 1'b0;
    s_d.stack_push     = 1'b0;
    s_d.stack_pop      = 1'b0;
    s_d.presc_clear    = 1'b0;
    s_d.wdt_clear      = 1'b0;
    s_d.int_enable_set = 1'b0;
    unique case (s_q.quarter)
      Q1: s_d.quarter = Q2;
      Q2:
      begin
        s_d.quarter = Q3;
        // Pins, not the output latch, for port reads
        s_d.operand = (faddr == `MID_PORT_B_ADDR) ? s_q.pins_sync : file_rdata_i;
      end
      Q3: s_d.quarter = Q4;
      Q4:
      begin
        s_d.quarter = Q1;
        if (s_q.asleep)
        begin
          // Prefetched word waits until wake
          if (wake_i)
            s_d.asleep = 1'b0;
        end
        else
        begin
          s_d.instr = pm_data_i;
          s_d.pc    = 13'(s_q.pc + 13'h0001);
          // Flushing loads a no-operation for the second cycle
          if (alu.skip)
            s_d.instr = `MID_NOP_WORD;
          if (dec.op inside {call_subroutine, jump_absolute})
          begin
            s_d.instr = `MID_NOP_WORD;
            s_d.pc    = {pclath_page_i, s_q.instr[`MID_TGT_MSB:0]};
          end
          if (dec.op == call_subroutine)
          begin
            s_d.stack_push = 1'b1;
            s_d.ret_addr   = s_q.pc;
          end
          if (dec.op inside {return_from_call, return_from_interrupt, return_with_literal})
          begin
            s_d.instr     = `MID_NOP_WORD;
            s_d.pc        = stack_tos_i;
            s_d.stack_pop = 1'b1;
          end
          s_d.int_enable_set = (dec.op == return_from_interrupt);
          if (dec.wr_acc)
            s_d.acc = alu.value;
          if (dec.wr_file)
          begin
            s_d.file_we    = 1'b1;
            s_d.file_waddr = faddr;
            s_d.file_wdata = alu.value;
            // Prescaler clear only when it serves the timer
            s_d.presc_clear = (faddr == `MID_TIMER_ADDR) && presc_on_timer_i;
          end
          if (alu.upd_carry)
            s_d.carry = alu.carry;
          if (alu.upd_digit)
            s_d.digit_carry_flag = alu.digit_carry_flag;
          if (alu.upd_zero)
            s_d.zero = alu.zero;
          if (dec.op == enter_standby)
          begin
            s_d.asleep               = 1'b1;
            s_d.timeout_status_bit   = 1'b1;
            s_d.powerdown_status_bit = 1'b0;
          end
          if (dec.op == clear_watchdog_count)
          begin
            s_d.wdt_clear            = 1'b1;
            s_d.timeout_status_bit   = 1'b1;
            s_d.powerdown_status_bit = 1'b1;
          end
        end
      end
    endcase
  end

  // Register the whole state; reset loads constants only
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      s_q                      <= '0;
      s_q.quarter              <= Q1;
      s_q.pc                   <= `MID_RESET_PC;
      s_q.instr                <= `MID_NOP_WORD;
      s_q.timeout_status_bit   <= `MID_RESET_TIMEOUT;
      s_q.powerdown_status_bit <= `MID_RESET_POWERDOWN;
    end
    else
      s_q <= s_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pm_addr_o              = s_q.pc;
  assign file_raddr_o           = faddr;
  assign file_we_o              = s_q.file_we;
  assign file_waddr_o           = s_q.file_waddr;
  assign file_wdata_o           = s_q.file_wdata;
  assign stack_push_o           = s_q.stack_push;
  assign stack_push_addr_o      = s_q.ret_addr;
  assign stack_pop_o            = s_q.stack_pop;
  assign presc_clear_o          = s_q.presc_clear;
  assign wdt_clear_o            = s_q.wdt_clear;
  assign int_enable_set_o       = s_q.int_enable_set;
  assign acc_o                  = s_q.acc;
  assign carry_o                = s_q.carry;
  assign digit_carry_flag_o     = s_q.digit_carry_flag;
  assign zero_o                 = s_q.zero;
  assign timeout_status_bit_o   = s_q.timeout_status_bit;
  assign powerdown_status_bit_o = s_q.powerdown_status_bit;
  assign standby_o              = s_q.asleep;
  assign quarter_o              = s_q.quarter;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  logic [7:0] sub_ref;
  assign sub_ref = 8'(s_q.instr[`MID_LIT_MSB:0] - s_q.acc);

  AST_DEC_SKIP: assert property (exec && dec.op == decrement_skip_zero
    |=> s_q.instr == (($past(s_q.operand) == 8'h01) ? `MID_NOP_WORD : $past(pm_data_i))
        && s_q.zero == $past(s_q.zero))
    else $error("decrement skip flushed wrongly or touched zero");
  AST_INC_SKIP: assert property (exec && dec.op == increment_skip_zero && s_q.operand == 8'hFF
    |=> s_q.instr == `MID_NOP_WORD && s_q.carry == $past(s_q.carry))
    else $error("increment skip did not flush or touched carry");
  AST_ROT_LEFT: assert property (exec && dec.op == rotate_left_carry
    |=> s_q.carry == $past(s_q.operand[7]) && s_q.zero == $past(s_q.zero))
    else $error("rotate left carry wrong");
  AST_ROT_RIGHT: assert property (exec && dec.op == rotate_right_carry
    |=> s_q.carry == $past(s_q.operand[0]))
    else $error("rotate right carry wrong");
  AST_TEST_CLEAR: assert property (exec && dec.op == bit_test_skip_clear
    |=> s_q.instr == ($past(s_q.operand[s_q.instr[`MID_BIT_MSB:`MID_BIT_LSB]])
        ? $past(pm_data_i) : `MID_NOP_WORD))
    else $error("bit test skip on clear bit wrong");
  AST_SUB_LIT: assert property (exec && dec.op == subtract_acc_from_literal
    |=> s_q.acc == $past(sub_ref))
    else $error("literal subtract result wrong");
  AST_OR_LIT: assert property (exec && dec.op == or_literal_acc
    |=> s_q.acc == $past(s_q.acc | s_q.instr[`MID_LIT_MSB:0])
        && s_q.zero == (s_q.acc == 8'h00) && s_q.carry == $past(s_q.carry))
    else $error("literal or result or flags wrong");
  AST_RET_LIT: assert property (exec && dec.op == return_with_literal
    |=> s_q.pc == $past(stack_tos_i) && s_q.stack_pop && s_q.instr == `MID_NOP_WORD
        && s_q.acc == $past(s_q.instr[`MID_LIT_MSB:0]) && s_q.zero == $past(s_q.zero))
    else $error("return with literal did not pop, flush or load");
  AST_STANDBY: assert property (exec && dec.op == enter_standby
    |=> s_q.asleep && !s_q.powerdown_status_bit && s_q.timeout_status_bit)
    else $error("standby bits wrong");
  AST_PORT_PINS: assert property (s_q.quarter == Q2 && faddr == `MID_PORT_B_ADDR
    |=> s_q.operand == $past(s_q.pins_sync))
    else $error("port read did not use pins");
  AST_PRESC: assert property (exec && dec.wr_file && faddr == `MID_TIMER_ADDR && presc_on_timer_i
    |=> presc_clear_o && file_we_o)
    else $error("prescaler not cleared");
  AST_JUMP: assert property (exec && dec.op == jump_absolute
    |=> s_q.instr == `MID_NOP_WORD ##4 !s_q.file_we)
    else $error("jump second cycle not a no-operation");
  AST_QUARTERS: assert property (s_q.quarter == Q1
    |=> s_q.quarter == Q2 ##1 s_q.quarter == Q3 ##1 s_q.quarter == Q4 ##1 s_q.quarter == Q1)
    else $error("quarter sequence broken");

  COV_CALL: cover property (exec && dec.op == call_subroutine);
  COV_SKIP: cover property (exec && alu.skip);
  COV_WAKE: cover property (s_q.asleep ##1 !s_q.asleep);

endmodule : mid_core
`default_nettype wire

// [hdl/mid_params.svh]
`ifndef MID_PARAMS_SVH
`define MID_PARAMS_SVH

// ****************************************************************
// Clock and field layout
// ****************************************************************
`define MID_CLK_PERIOD_NS   4
`define MID_FILE_MSB        6
`define MID_LIT_MSB         7
`define MID_TGT_MSB         10
`define MID_DEST_BIT        7
`define MID_BIT_LSB         7
`define MID_BIT_MSB         9

// ****************************************************************
// Fixed instruction words
// ****************************************************************
`define MID_NOP_WORD        14'h0000
`define MID_STANDBY_WORD    14'h0063
`define MID_WDT_CLR_WORD    14'h0064
`define MID_RET_INT_WORD    14'h0009
`define MID_RET_WORD        14'h0008

// ****************************************************************
// File addresses and reset values
// ****************************************************************
`define MID_TIMER_ADDR      7'h01
`define MID_PORT_B_ADDR     7'h06
`define MID_RESET_PC        13'h0000
`define MID_RESET_TIMEOUT   1'b1
`define MID_RESET_POWERDOWN 1'b1

`endif

// [hdl/mid_pkg.sv]
`default_nettype none
package mid_pkg;

  // Instruction quarters, Gray coded along the cycle
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b11,
    Q4 = 2'b10
  } mid_quarter_t;

  typedef enum logic [5:0] {
    no_operation, store_acc_to_file, clear_file, clear_accumulator,
    subtract_acc_from_file, decrement_file, or_acc_with_file,
    and_acc_with_file, xor_acc_with_file, add_acc_to_file, move_file,
    complement_file, increment_file, decrement_skip_zero,
    rotate_right_carry, rotate_left_carry, swap_file_nibbles,
    increment_skip_zero, bit_clear_file, bit_set_file,
    bit_test_skip_clear, bit_test_skip_set, call_subroutine,
    jump_absolute, load_literal_acc, return_with_literal, or_literal_acc,
    and_literal_acc, xor_literal_acc, subtract_acc_from_literal,
    add_literal_acc, return_from_call, return_from_interrupt,
    enter_standby, clear_watchdog_count
  } mid_op_t;

  typedef struct packed {
    mid_op_t op;
    logic    wr_file;
    logic    wr_acc;
  } mid_dec_t;

  typedef struct packed {
    logic [7:0] value;
    logic       carry;
    logic       digit_carry_flag;
    logic       zero;
    logic       upd_carry;
    logic       upd_digit;
    logic       upd_zero;
    logic       skip;
  } mid_alu_res_t;

  typedef struct packed {
    mid_quarter_t quarter;
    logic [12:0]  pc;
    logic [12:0]  ret_addr;
    logic [13:0]  instr;
    logic [7:0]   acc;
    logic [7:0]   operand;
    logic         carry;
    logic         digit_carry_flag;
    logic         zero;
    logic         timeout_status_bit;
    logic         powerdown_status_bit;
    logic         asleep;
    logic         file_we;
    logic [6:0]   file_waddr;
    logic [7:0]   file_wdata;
    logic         stack_push;
    logic         stack_pop;
    logic         presc_clear;
    logic         wdt_clear;
    logic         int_enable_set;
    logic [7:0]   pins_meta;
    logic [7:0]   pins_sync;
  } mid_core_state_t;

endpackage : mid_pkg
`default_nettype wire

// [hdl/mid_alu.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mid_params.svh"
module mid_alu
  import mid_pkg::*;
(
  // Operation select
  input  wire mid_op_t      op_i,
  // Operands
  input  wire logic [7:0]   acc_i,
  input  wire logic [7:0]   opnd_i,
  input  wire logic [2:0]   bit_sel_i,
  input  wire logic         carry_i,
  // Result and flag updates
  output var  mid_alu_res_t res_o
);

  // ****************************************************************
  // Shared adder
  // ****************************************************************
  // Carry out and nibble carry; subtraction feeds inverted accumulator
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction : add8

  // ****************************************************************
  // Operation table
  // ****************************************************************
  // Carry after subtraction means no borrow
  always_comb
  begin
    logic [9:0] sum;
    logic [7:0] mask;
    sum   = 10'h000;
    mask  = 8'(8'h01 << bit_sel_i);
    res_o = '0;
    case (op_i)
      store_acc_to_file: res_o.value = acc_i;
      clear_file, clear_accumulator: res_o.upd_zero = 1'b1;
      subtract_acc_from_file, subtract_acc_from_literal:
      begin
        sum = add8(opnd_i, ~acc_i, 1'b1);
        res_o.upd_carry = 1'b1;
        res_o.upd_digit = 1'b1;
        res_o.upd_zero  = 1'b1;
      end
      add_acc_to_file, add_literal_acc:
      begin
        sum = add8(acc_i, opnd_i, 1'b0);
        res_o.upd_carry = 1'b1;
        res_o.upd_digit = 1'b1;
        res_o.upd_zero  = 1'b1;
      end
      decrement_file, decrement_skip_zero:
      begin
        res_o.value    = 8'(opnd_i - 8'h01);
        res_o.upd_zero = (op_i == decrement_file);
        res_o.skip     = (op_i == decrement_skip_zero) && (opnd_i == 8'h01);
      end
      increment_file, increment_skip_zero:
      begin
        res_o.value    = 8'(opnd_i + 8'h01);
        res_o.upd_zero = (op_i == increment_file);
        res_o.skip     = (op_i == increment_skip_zero) && (opnd_i == 8'hFF);
      end
      or_acc_with_file, or_literal_acc:
      begin
        res_o.value    = acc_i | opnd_i;
        res_o.upd_zero = 1'b1;
      end
      and_acc_with_file, and_literal_acc:
      begin
        res_o.value    = acc_i & opnd_i;
        res_o.upd_zero = 1'b1;
      end
      xor_acc_with_file, xor_literal_acc:
      begin
        res_o.value    = acc_i ^ opnd_i;
        res_o.upd_zero = 1'b1;
      end
      move_file, complement_file:
      begin
        res_o.value    = (op_i == move_file) ? opnd_i : ~opnd_i;
        res_o.upd_zero = 1'b1;
      end
      rotate_left_carry:
      begin
        res_o.value     = {opnd_i[6:0], carry_i};
        res_o.carry     = opnd_i[7];
        res_o.upd_carry = 1'b1;
      end
      rotate_right_carry:
      begin
        res_o.value     = {carry_i, opnd_i[7:1]};
        res_o.carry     = opnd_i[0];
        res_o.upd_carry = 1'b1;
      end
      swap_file_nibbles: res_o.value = {opnd_i[3:0], opnd_i[7:4]};
      bit_clear_file: res_o.value = opnd_i & ~mask;
      bit_set_file: res_o.value = opnd_i | mask;
      bit_test_skip_clear: res_o.skip = ((opnd_i & mask) == 8'h00);
      bit_test_skip_set: res_o.skip = ((opnd_i & mask) != 8'h00);
      load_literal_acc, return_with_literal: res_o.value = opnd_i;
      default: res_o.value = 8'h00;
    endcase
    if (res_o.upd_carry && res_o.upd_digit)
    begin
      res_o.value            = sum[7:0];
      res_o.carry            = sum[9];
      res_o.digit_carry_flag = sum[8];
    end
    res_o.zero = (res_o.value == 8'h00);
  end

endmodule : mid_alu
`default_nettype wire

// [tb/mid_pm_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****
// Program memory model
// ****
module mid_pm_model
(
  // Fetch port
  input  wire logic [12:0] addr_i,
  output logic [13:0]      data_o
);
  logic [13:0] mem [32];
  // Combinational read, wraps every 32 words to stay small
  assign data_o = mem[addr_i[4:0]];
endmodule : mid_pm_model
`default_nettype wire

// [tb/mid_core_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module mid_core_tb_top;
  import mid_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  port_b_pins_i = 8'h00;
  logic [12:0] pm_addr_o;
  logic [13:0] pm_data_i;
  logic [6:0]  file_raddr_o, file_waddr_o;
  logic [7:0]  file_rdata_i, file_wdata_o, acc_o, r;
  logic        file_we_o, carry_o, dc_o, zero_o, standby_o, pd_o, to_o;
  logic [7:0]  fmem [128];
  logic [10:0] exp_q [$];
  logic [10:0] prev_q = 11'h000;
  int          mismatches = 0, tests_run = 0, cyc = 0;
  mid_pm_model u_pm (.addr_i(pm_addr_o), .data_o(pm_data_i));
  mid_core u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .pm_addr_o(pm_addr_o),
    .pm_data_i(pm_data_i), .file_raddr_o(file_raddr_o), .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .port_b_pins_i(port_b_pins_i), .stack_push_o(), .stack_push_addr_o(), .stack_pop_o(),
    .stack_tos_i(13'h0010), .pclath_page_i(2'b00), .presc_on_timer_i(1'b1), .wake_i(1'b0),
    .presc_clear_o(), .wdt_clear_o(), .int_enable_set_o(), .acc_o(acc_o), .carry_o(carry_o),
    .digit_carry_flag_o(dc_o), .zero_o(zero_o), .timeout_status_bit_o(to_o),
    .powerdown_status_bit_o(pd_o), .standby_o(standby_o), .quarter_o());
  // File space: combinational read, written on the write pulse
  assign file_rdata_i = fmem[file_raddr_o];
  always @(posedge mclk_i) if (file_we_o) fmem[file_waddr_o] <= file_wdata_o;
  // Clock, and random pin levels that no instruction here reads
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) port_b_pins_i <= 8'($urandom);
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] state exp %h seen %h", exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // Store a word; note the expected {zero, digit carry, carry, acc} if flagged
  task automatic ld(input logic [4:0] a, input logic [13:0] w, input logic [11:0] e);
    u_pm.mem[a] = w;
    if (e[11]) exp_q.push_back(e[10:0]);
  endtask : ld
  // Monitor: every change of {zero, digit carry, carry, acc} takes the oldest note; also the hang limit
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      mismatches++;
      finish_test();
    end
    else if (!reset_i && {zero_o, dc_o, carry_o, acc_o} !== prev_q)
    begin
      prev_q <= {zero_o, dc_o, carry_o, acc_o};
      check({zero_o, dc_o, carry_o, acc_o}, exp_q.size() > 0 ? exp_q.pop_front() : 11'h7FF);
    end
  end
  // Program; fillers load 0x11 and would show up as an extra change if run
  initial
  begin
    void'($urandom(32'hE9458867));
    r = 8'($urandom) | 8'h01;
    for (int i = 0; i < 128; i++) fmem[i] = 8'h00;
    for (int i = 0; i < 32; i++) u_pm.mem[i] = 14'h0000;
    fmem[32] = 8'hFF;
    fmem[33] = 8'h40;
    fmem[34] = 8'h81;
    ld(0, {6'h30, r}, {4'h8, r});
    ld(1, {6'h3A, r}, 12'hC00);
    ld(2, 14'h3801, 12'h801);
    ld(3, 14'h3C03, 12'hB02);
    ld(4, 14'h0F20, 12'hB00);
    ld(5, 14'h3011, 12'h000);
    ld(6, 14'h0D21, 12'hA81);
    ld(7, 14'h1F21, 12'h000);
    ld(8, 14'h3011, 12'h000);
    ld(9, 14'h1BA1, 12'h000);
    ld(10, 14'h3011, 12'h000);
    ld(11, 14'h06A2, 12'hE81);
    ld(12, 14'h0B22, 12'hEFF);
    ld(13, 14'h3477, 12'hE77);
    ld(14, 14'h3011, 12'h000);
    ld(16, 14'h0C21, 12'hE20);
    ld(17, 14'h3EE0, 12'hD00);
    ld(18, 14'h303F, 12'hD3F);
    ld(19, 14'h00A3, 12'h000);
    ld(20, 14'h0E23, 12'hDF3);
    ld(21, 14'h390F, 12'h903);
    ld(22, 14'h0723, 12'hA42);
    ld(23, 14'h0923, 12'hAC0);
    ld(24, 14'h0223, 12'hA7F);
    ld(25, 14'h17A3, 12'h000);
    ld(26, 14'h0823, 12'hABF);
    ld(27, 14'h281D, 12'h000);
    ld(28, 14'h3011, 12'h000);
    ld(29, 14'h0100, 12'hE00);
    ld(30, 14'h0063, 12'h000);
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge mclk_i);
    repeat (12) @(posedge mclk_i);
    check({8'h00, to_o, standby_o, pd_o}, 11'h006);
    $display("program test done");
    finish_test();
  end
endmodule : mid_core_tb_top
`default_nettype wire
